/* File: logic/vcs_cfg.svh */
// constants for the video crop and scale block: register indices, field
// positions, reset values and picture sizes; included by package and top.
`ifndef VCS_CFG_SVH
`define VCS_CFG_SVH
`define VCS_LANES 8
`define VCS_LIVE 4
`define VCS_HOFF_RST 10'h020
`define VCS_HACT_RST 10'h2D0
`define VCS_VOFF_RST 9'h006
`define VCS_VACT_RST 9'h0F0
`define VCS_RATIO_RST 16'hFFFF
`define VCS_W720 10'h2D0
`define VCS_W704 10'h2C0
`define VCS_W640 10'h280
`define VCS_HPH_ONE 6'h20
`define VCS_VPH_ONE 5'h10
`define VCS_IDX_STRIDE 8'h10
`define VCS_IDX_CROP 8'h02
`define VCS_IDX_LFLT 8'h80
`define VCS_IDX_PFLT 8'h85
`define VCS_IDX_PCROP 8'h8B
`define VCS_IDX_MANCTL 8'hC0
`define VCS_IDX_PBCTL 8'hC1
`define VCS_IDX_STAT 8'hC2
`define VCS_PB_AUTO 0
`define VCS_PB_DVR 1
`define VCS_PB_WSEL 2
`define VCS_PB_SEL 4
`define VCS_MAN_H 0
`define VCS_MAN_V 1
`define VCS_FLT_V 2
`endif

/* File: logic/vcs_pkg.sv */
// types of the video crop and scale block
// assumes vcs_cfg.svh is on the include path
`include "vcs_cfg.svh"
package vcs_pkg;
  typedef struct packed {
    logic [`VCS_LANES-1:0][9:0] hoff;
    logic [`VCS_LANES-1:0][9:0] hact;
    logic [`VCS_LANES-1:0][8:0] voff;
    logic [`VCS_LANES-1:0][8:0] vact;
    logic [`VCS_LANES-1:0][3:0] flt;
    logic [`VCS_LANES-1:0][15:0] hrat;
    logic [`VCS_LANES-1:0][15:0] vrat;
    logic [1:0] manctl;
    logic [11:0] pbctl;
    logic [15:0] rdata;
    logic ack;
  } vcs_regs_s;

  typedef struct packed {
    logic [9:0] pix;
    logic [8:0] line;
    logic [15:0] hacc;
    logic [15:0] vacc;
    logic lemit;
    logic [3:0] lph;
    logic [7:0] s0;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] prevf;
    logic [9:0] ox;
    logic [1:0] chid;
    logic first;
    logic vprev;
    logic [7:0] odata;
    logic ovalid;
    logic osof;
  } vcs_lane_s;
endpackage : vcs_pkg

/* File: logic/vcs_top.sv */
// crop and free down-scale for four live and four playback display lanes
// assumes pixel streams, references and channel id come from the decoders
// on MCLK_I; software reaches the registers over Avalon-MM
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`include "vcs_cfg.svh"

// Contract
// [RL1] window starts at vertical and horizontal offsets
// [RL2] pass active count lines and pixels
// [RL3] pixel offset counted from horizontal reference
// [RL4] crop counts are unscaled pixels
// [RL5] software keeps pixel offset plus count short
// [RL6] software uses offset 32, count 720
// [RL7] line offset and count use unscaled lines
// [RL8] software keeps line offset plus count short
// [RL9] software uses 6/240 or 5/288 lines
// [RL10] free scaling only on display lanes
// [RL11] horizontal filter then 32-phase interpolator
// [RL12] vertical filter with 16 phases
// [RL13] ratio all-ones outputs active counts exactly
// [RL14] 16-bit ratios reduce output counts
// [RL15] ratio is out/in times 0xFFFF
// [RL16] autocrop off uses playback offset registers
// [RL17] autocrop on extracts selected channel
// [RL18] record style picks normal or dvr layout
// [RL19] width select gives 720, 704, 640
// [RL20] manual offset control overrides auto offsets
// [RL21] four playback lanes scale freely
// [RL22] autocrop locates channel by decoded id
// [RL23] counters restart at each reference
module vcs_top
(
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic [9:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic [31:0] LIVE_DATA_I,
  input wire logic [3:0] LIVE_VALID_I,
  input wire logic [3:0] LIVE_HREF_I,
  input wire logic [3:0] LIVE_VREF_I,
  input wire logic [7:0] PB_DATA_I,
  input wire logic PB_VALID_I,
  input wire logic PB_HREF_I,
  input wire logic PB_VREF_I,
  input wire logic [1:0] PB_CHID_I,
  input wire logic PB_CHID_VALID_I,
  output logic [63:0] OUT_DATA_O,
  output logic [7:0] OUT_VALID_O,
  output logic [7:0] OUT_SOF_O
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  localparam vcs_pkg::vcs_regs_s REGS_RST = '{
    hoff: {`VCS_LANES{`VCS_HOFF_RST}},
    hact: {`VCS_LANES{`VCS_HACT_RST}},
    voff: {`VCS_LANES{`VCS_VOFF_RST}},
    vact: {`VCS_LANES{`VCS_VACT_RST}},
    flt: '0,
    hrat: {`VCS_LANES{`VCS_RATIO_RST}},
    vrat: {`VCS_LANES{`VCS_RATIO_RST}},
    manctl: '0,
    pbctl: '0,
    rdata: '0,
    ack: 1'b0
  };

  vcs_pkg::vcs_regs_s r;
  vcs_pkg::vcs_regs_s next_r;
  logic [7:0] idx;
  logic [15:0] rd;
  logic [15:0] wd;
  logic [7:0] lane_act;
  logic [1:0] chid_seen;

  function automatic logic [7:0] crop_base(input int l);
    if (l < `VCS_LIVE)
      crop_base = 8'(l) * `VCS_IDX_STRIDE + `VCS_IDX_CROP;
    else
      crop_base = 8'(l - `VCS_LIVE) * `VCS_IDX_STRIDE + `VCS_IDX_PCROP;
  endfunction : crop_base

  function automatic logic [7:0] flt_base(input int l);
    if (l < `VCS_LIVE)
      flt_base = 8'(l) * `VCS_IDX_STRIDE + `VCS_IDX_LFLT;
    else
      flt_base = 8'(l - `VCS_LIVE) * `VCS_IDX_STRIDE + `VCS_IDX_PFLT;
  endfunction : flt_base

  function automatic logic [15:0] merge(input logic [15:0] o);
    merge[15:8] = AVS_BYTEENABLE_I[1] ? AVS_WRITEDATA_I[15:8] : o[15:8];
    merge[7:0] = AVS_BYTEENABLE_I[0] ? AVS_WRITEDATA_I[7:0] : o[7:0];
  endfunction : merge

  assign idx = AVS_ADDRESS_I[9:2];
  // one wait cycle per access; the answer edge is the second one after the request is driven
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~r.ack;
  assign AVS_READDATA_O = {16'h0000, r.rdata};

  always_comb
  begin
    next_r = r;
    wd = 16'h0000;
    rd = 16'h0000;
    next_r.ack = (AVS_READ_I | AVS_WRITE_I) & ~r.ack;
    for (int l = 0; l < `VCS_LANES; l++)
    begin
      if (idx == crop_base(l))
        rd = 16'(r.hoff[l]);
      if (idx == crop_base(l) + 8'h01)
        rd = 16'(r.hact[l]);
      if (idx == crop_base(l) + 8'h02)
        rd = 16'(r.voff[l]);
      if (idx == crop_base(l) + 8'h03)
        rd = 16'(r.vact[l]);
      if (idx == flt_base(l))
        rd = 16'(r.flt[l]);
      if (idx == flt_base(l) + 8'h01)
        rd = r.hrat[l];
      if (idx == flt_base(l) + 8'h02)
        rd = r.vrat[l];
    end
    if (idx == `VCS_IDX_MANCTL)
      rd = 16'(r.manctl);
    if (idx == `VCS_IDX_PBCTL)
      rd = 16'(r.pbctl);
    if (idx == `VCS_IDX_STAT)
      rd = {6'h00, chid_seen, lane_act};
    // unmapped indices read zero and ignore writes
    if (AVS_READ_I & ~r.ack)
      next_r.rdata = rd;
    if (AVS_WRITE_I & r.ack)
    begin
      for (int l = 0; l < `VCS_LANES; l++)
      begin
        if (idx == crop_base(l))
          next_r.hoff[l] = 10'(merge(16'(r.hoff[l])));
        if (idx == crop_base(l) + 8'h01)
          next_r.hact[l] = 10'(merge(16'(r.hact[l])));
        if (idx == crop_base(l) + 8'h02)
          next_r.voff[l] = 9'(merge(16'(r.voff[l])));
        if (idx == crop_base(l) + 8'h03)
          next_r.vact[l] = 9'(merge(16'(r.vact[l])));
        if (idx == flt_base(l))
          next_r.flt[l] = 4'(merge(16'(r.flt[l])));
        if (idx == flt_base(l) + 8'h01)
          next_r.hrat[l] = merge(r.hrat[l]);
        if (idx == flt_base(l) + 8'h02)
          next_r.vrat[l] = merge(r.vrat[l]);
      end
      wd = merge({4'h0, r.pbctl});
      if (idx == `VCS_IDX_PBCTL)
        next_r.pbctl = wd[11:0];
      wd = merge(16'(r.manctl));
      if (idx == `VCS_IDX_MANCTL)
        next_r.manctl = wd[1:0];
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      r <= REGS_RST;
    else
      r <= next_r;
  end

  // ----------------------------------------------------------------
  // crop and scale lanes: 0..3 live, 4..7 playback
  // ----------------------------------------------------------------
  for (genvar l = 0; l < `VCS_LANES; l++)
  begin : g_lane
    vcs_pkg::vcs_lane_s q;
    vcs_pkg::vcs_lane_s next_q;
    logic [7:0] d;
    logic v;
    logic h;
    logic vr;
    logic cv;
    logic [1:0] sel;
    logic auto_en;
    logic dvr;
    logic [9:0] w;
    logic [9:0] bh;
    logic [8:0] bv;
    logic [1:0] qd;
    logic [9:0] hoff;
    logic [9:0] hact;
    logic [8:0] voff;
    logic [8:0] vact;
    logic [8:0] nl;
    logic fld_ok;
    logic in_h;
    logic in_v;
    logic in_vn;
    logic lane_on;
    logic [9:0] f;
    logic [9:0] vf;
    logic [16:0] hnx;
    logic [16:0] vnx;
    logic [14:0] hsum;
    logic [11:0] vsum;
    logic [7:0] hout;
    logic [7:0] b;
    logic wr;
    logic [7:0] lbuf [0:1023];

    if (l < `VCS_LIVE)
    begin : g_live
      assign d = LIVE_DATA_I[8*l +: 8];
      assign v = LIVE_VALID_I[l];
      assign h = LIVE_HREF_I[l];
      assign vr = LIVE_VREF_I[l];
      assign cv = 1'b0;
      assign sel = 2'h0;
      assign auto_en = 1'b0;
    end
    else
    begin : g_play
      assign d = PB_DATA_I;
      assign v = PB_VALID_I;
      assign h = PB_HREF_I;
      assign vr = PB_VREF_I;
      assign cv = PB_CHID_VALID_I;
      assign sel = r.pbctl[`VCS_PB_SEL + 2*(l-`VCS_LIVE) +: 2];
      assign auto_en = r.pbctl[`VCS_PB_AUTO];
    end
    assign dvr = r.pbctl[`VCS_PB_DVR];

    // window selection
    always_comb
    begin
      case (r.pbctl[`VCS_PB_WSEL +: 2])
        2'h0: w = `VCS_W720;
        2'h1: w = `VCS_W704;
        default: w = `VCS_W640;
      endcase
      // normal layout rotates channels through the quadrants per field
      qd = sel - q.chid;
      bh = r.manctl[`VCS_MAN_H] ? r.hoff[l] : `VCS_HOFF_RST + ((`VCS_W720 - w) >> 1); //RL20
      bv = r.manctl[`VCS_MAN_V] ? r.voff[l] : `VCS_VOFF_RST; //RL20
      hoff = r.hoff[l]; //RL1 RL16
      hact = r.hact[l]; //RL2
      voff = r.voff[l];
      vact = r.vact[l];
      fld_ok = 1'b1;
      if (auto_en) //RL17
      begin
        if (dvr) //RL18
        begin
          hoff = bh;
          hact = w; //RL19
          voff = bv;
          fld_ok = (q.chid == sel); //RL22
        end
        else
        begin
          hact = w >> 1;
          hoff = bh + (qd[0] ? (w >> 1) : 10'h000); //RL22
          vact = r.vact[l] >> 1;
          voff = bv + (qd[1] ? vact : 9'h000);
        end
      end
      nl = q.line + 9'h001;
      in_h = (q.pix >= hoff) && ({1'b0, q.pix} < {1'b0, hoff} + {1'b0, hact}); //RL3 RL4
      in_v = (q.line >= voff) && ({1'b0, q.line} < {1'b0, voff} + {1'b0, vact}); //RL7
      in_vn = (nl >= voff) && ({1'b0, nl} < {1'b0, voff} + {1'b0, vact});
      lane_on = in_h & in_v & fld_ok;
    end

    // filters and phase arithmetic
    always_comb
    begin
      case (r.flt[l][1:0]) //RL11
        2'h0: f = {2'h0, d};
        2'h1: f = ({2'h0, d} + {2'h0, q.s0}) >> 1;
        2'h2: f = ({2'h0, d} + {1'b0, q.s0, 1'b0} + {2'h0, q.s1}) >> 2;
        default: f = ({2'h0, d} + {2'h0, q.s0} + {2'h0, q.s1} + {2'h0, q.s2}) >> 2;
      endcase
      // ratio plus one, so all-ones gives one output per input
      hnx = {1'b0, q.hacc} + {1'b0, r.hrat[l]} + 17'h00001; //RL14 RL15 RL13
      vnx = {1'b0, q.vacc} + {1'b0, r.vrat[l]} + 17'h00001; //RL14 RL15 RL13
      // phase is how far the output point lags the newest sample
      hsum = 15'(f[7:0]) * 15'(`VCS_HPH_ONE - {1'b0, hnx[15:11]})
        + 15'(q.prevf) * 15'(hnx[15:11]); //RL11
      hout = hsum[12:5];
      // the first window line of a field has no previous line in the store
      b = q.vprev ? lbuf[q.ox] : hout;
      case (r.flt[l][`VCS_FLT_V +: 2]) //RL12
        2'h0: vf = {2'h0, hout};
        2'h1: vf = ({2'h0, hout} + {2'h0, b}) >> 1;
        2'h2: vf = ({2'h0, hout} + {1'b0, hout, 1'b0} + {2'h0, b}) >> 2;
        default: vf = ({2'h0, hout} + {1'b0, b, 1'b0} + {2'h0, b}) >> 2;
      endcase
      vsum = 12'(vf[7:0]) * 12'(`VCS_VPH_ONE - {1'b0, q.lph})
        + 12'(b) * 12'(q.lph); //RL12
    end

    // counters and output
    always_comb
    begin
      next_q = q;
      next_q.ovalid = 1'b0;
      next_q.osof = 1'b0;
      wr = 1'b0;
      if (cv)
        next_q.chid = PB_CHID_I; //RL22
      if (h)
      begin
        next_q.pix = 10'h000; //RL23
        next_q.hacc = 16'h0000;
        next_q.ox = 10'h000;
        next_q.line = nl;
        next_q.lemit = 1'b0;
        next_q.vprev = in_v & fld_ok;
        if (in_vn & fld_ok)
        begin
          next_q.vacc = vnx[15:0];
          next_q.lemit = vnx[16];
          next_q.lph = vnx[15:12];
        end
      end
      else if (v)
      begin
        next_q.pix = q.pix + 10'h001;
        if (lane_on) //RL1 RL2
        begin
          next_q.s2 = q.s1;
          next_q.s1 = q.s0;
          next_q.s0 = d;
          next_q.prevf = f[7:0];
          next_q.hacc = hnx[15:0];
          if (hnx[16])
          begin
            wr = 1'b1;
            next_q.ox = q.ox + 10'h001;
            if (q.lemit) //RL10 RL21
            begin
              next_q.odata = vsum[11:4];
              next_q.ovalid = 1'b1;
              next_q.osof = q.first;
              next_q.first = 1'b0;
            end
          end
        end
      end
      if (vr)
      begin
        next_q.line = 9'h000; //RL23
        next_q.vacc = 16'h0000;
        next_q.lemit = 1'b0;
        next_q.first = 1'b1;
        next_q.vprev = 1'b0;
      end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
      if (!RST_N_I)
        q <= '0;
      else
        q <= next_q;
    end

    // previous line store for the vertical stage; no reset needed
    always_ff @(posedge MCLK_I)
    begin
      if (wr)
        lbuf[q.ox] <= hout;
    end

    assign OUT_DATA_O[8*l +: 8] = q.odata;
    assign OUT_VALID_O[l] = q.ovalid;
    assign OUT_SOF_O[l] = q.osof;
    assign lane_act[l] = lane_on;
  end

  assign chid_seen = g_lane[`VCS_LIVE].q.chid;

endmodule : vcs_top

/* File: tb/vcs_src.sv */
// stand-in for a video decoder: one pixel stream with line and field refs
// assumes the bench calls field() from its own process
`timescale 1ns/1ps
module vcs_src
(
  input wire logic clk_i,
  output logic [7:0] data_o,
  output logic valid_o,
  output logic href_o,
  output logic vref_o
);
  initial
  begin
    data_o = 8'h5A;
    valid_o = 1'b0;
    href_o = 1'b0;
    vref_o = 1'b0;
  end

  // ----------------------------------------
  // field generation
  // ----------------------------------------
  // released data is inverted so a stale byte never looks like a pixel
  task automatic field(input int nl, input int np, input logic [7:0] b);
    for (int l = 0; l < nl; l++)
    begin
      @(posedge clk_i);
      href_o <= 1'b1;
      vref_o <= (l == 0);
      valid_o <= 1'b0;
      data_o <= ~data_o;
      for (int p = 0; p < np; p++)
      begin
        @(posedge clk_i);
        href_o <= 1'b0;
        vref_o <= 1'b0;
        valid_o <= 1'b1;
        data_o <= b + 8'(l * 16 + p);
      end
    end
    @(posedge clk_i);
    valid_o <= 1'b0;
    data_o <= ~data_o;
  endtask : field
endmodule : vcs_src

/* File: tb/vcs_top_chk.sv */
// port checks of the crop and scale block
// assumes one clock and a bus master that holds requests until served
`timescale 1ns/1ps
module vcs_chk
(
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic [3:0] LIVE_VALID_I,
  input wire logic [3:0] LIVE_HREF_I,
  input wire logic PB_VALID_I,
  input wire logic PB_HREF_I,
  input wire logic [63:0] OUT_DATA_O,
  input wire logic [7:0] OUT_VALID_O,
  input wire logic [7:0] OUT_SOF_O
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);
  logic req;
  assign req = AVS_READ_I | AVS_WRITE_I;

  a_wait_one: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("request waited more than one cycle");
  a_wait_idle: assert property (!req |-> !AVS_WAITREQUEST_O)
    else $error("waitrequest without request");
  a_wait_first: assert property ($rose(req) |-> AVS_WAITREQUEST_O)
    else $error("new request not held off");
  a_rdata_top: assert property (AVS_READDATA_O[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_rdata_hold: assert property (!$stable(AVS_READDATA_O) |-> $past(req && AVS_READ_I && AVS_WAITREQUEST_O))
    else $error("read data moved without a read");
  a_live_pix: assert property (OUT_VALID_O[0] |-> $past(LIVE_VALID_I[0] && !LIVE_HREF_I[0]))
    else $error("live output without input pixel");
  a_pb_pix: assert property (OUT_VALID_O[4] |-> $past(PB_VALID_I && !PB_HREF_I))
    else $error("playback output without input pixel");
  a_sof_valid: assert property ((OUT_SOF_O & ~OUT_VALID_O) == 8'h00)
    else $error("start of field without pixel");
  a_data_hold: assert property (!OUT_VALID_O[0] |-> $stable(OUT_DATA_O[7:0]))
    else $error("output data moved between pixels");

  c_sof: cover property (OUT_SOF_O[0]);
  c_write: cover property (AVS_WRITE_I && !AVS_WAITREQUEST_O);
  c_read: cover property (AVS_READ_I && !AVS_WAITREQUEST_O);
endmodule : vcs_chk

bind vcs_top vcs_chk chk_u
(
  .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .LIVE_VALID_I(LIVE_VALID_I),
  .LIVE_HREF_I(LIVE_HREF_I), .PB_VALID_I(PB_VALID_I), .PB_HREF_I(PB_HREF_I),
  .OUT_DATA_O(OUT_DATA_O), .OUT_VALID_O(OUT_VALID_O), .OUT_SOF_O(OUT_SOF_O)
);

/* File: tb/tb_top.sv */
// self-checking bench: register bus, live lane 0 and playback lane 4 crop
// assumes the decoder stand-in feeds every lane with the same stream
`timescale 1ns/1ps
`include "vcs_cfg.svh"
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] adr = 10'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic [7:0] sd;
  logic sv, sh, svr;
  logic [1:0] chid = 2'h0;
  logic chv = 1'b0;
  logic [63:0] od;
  logic [7:0] ov, os;
  logic [31:0] lfsr = 32'h423A;
  logic cmpd = 1'b0;
  logic [7:0] expq[$];
  logic [7:0] expq4[$];
  logic [1:0] lid = 2'h0;
  logic pb_auto = 1'b0;
  logic pb_dvr = 1'b0;
  int errors = 0;
  int compares = 0;
  int nout, nsof, n4, n4s, nx;

  always #20 clk = ~clk;

  vcs_src src_u (.clk_i(clk), .data_o(sd), .valid_o(sv), .href_o(sh), .vref_o(svr));

  vcs_top dut_u
  (
    .MCLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'h3),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .LIVE_DATA_I({4{sd}}),
    .LIVE_VALID_I({4{sv}}), .LIVE_HREF_I({4{sh}}), .LIVE_VREF_I({4{svr}}),
    .PB_DATA_I(sd), .PB_VALID_I(sv), .PB_HREF_I(sh), .PB_VREF_I(svr),
    .PB_CHID_I(chid), .PB_CHID_VALID_I(chv), .OUT_DATA_O(od),
    .OUT_VALID_O(ov), .OUT_SOF_O(os)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic end_of_test();
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // waitrequest and read data are sampled at the rising edge that ends the wait
  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d,
                     output logic [31:0] q);
    int n;
    logic done;
    n = 0;
    @(posedge clk);
    adr <= {idx, 2'b00};
    wdat <= {16'h0, d};
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge clk);
      n++;
      done = (wreq === 1'b0);
      q = rdat;
    end
    while (!done && n < 50);
    rd <= 1'b0;
    wr <= 1'b0;
    if (!done)
      errors++;
  endtask : bus

  task automatic wreg(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wreg

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 16'h0, q);
    chk(q, exp, "register");
  endtask : rchk

  // one 7-line field of 12 pixels; window is lines 2..5, pixels 3..8
  // lane 4 auto windows run past the 12-pixel line, so pixels 3..11 survive:
  // dvr keeps all 4 lines of the selected channel, normal keeps the left
  // quadrant only, 2 lines each
  task automatic run(input int exp_n, input logic cmp);
    logic [7:0] b;
    int e4;
    lfsr = lfsr_next(lfsr);
    b = lfsr[7:0];
    chid <= lfsr[9:8];
    chv <= lfsr[10];
    if (lfsr[10])
      lid = lfsr[9:8];
    e4 = 24;
    if (pb_auto && pb_dvr)
      e4 = (lid == 2'h0) ? 36 : 0;
    else if (pb_auto)
      e4 = lid[0] ? 0 : 18;
    nout = 0;
    nsof = 0;
    n4 = 0;
    n4s = 0;
    nx = 0;
    cmpd = cmp;
    if (cmp)
      for (int l = 2; l < 6; l++)
        for (int p = 3; p < 9; p++)
        begin
          expq.push_back(b + 8'(l * 16 + p));
          expq4.push_back(b + 8'(l * 16 + p));
        end
    src_u.field(7, 12, b);
    repeat (3) @(posedge clk);
    chk(32'(nout), 32'(exp_n), "lane 0 count");
    chk(32'(n4), 32'(e4), "lane 4 count");
    chk(32'(n4s), (e4 > 0) ? 32'd1 : 32'd0, "lane 4 start of field");
    chk(32'(nsof), 32'd1, "start of field");
    chk(32'(nx), 32'd0, "idle lanes");
  endtask : run

  always @(negedge clk)
  begin
    if (((ov | os) & 8'hEE) !== 8'h00)
      nx++;
    if (ov[4] === 1'b1)
    begin
      n4++;
      if (os[4] === 1'b1)
        n4s++;
      if (cmpd)
        chk({24'h0, od[39:32]}, {24'h0, expq4.pop_front()}, "playback pixel");
    end
    if (ov[0] === 1'b1)
    begin
      nout++;
      if (os[0] === 1'b1)
        nsof++;
      if (cmpd)
        chk({24'h0, od[7:0]}, {24'h0, expq.pop_front()}, "pixel");
    end
  end

  initial
  begin
    repeat (6000) @(posedge clk);
    errors++;
    end_of_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h02, 32'(`VCS_HOFF_RST));
    rchk(8'h03, 32'(`VCS_HACT_RST));
    rchk(8'h04, 32'(`VCS_VOFF_RST));
    rchk(8'h05, 32'(`VCS_VACT_RST));
    rchk(8'h80, 32'h0);
    rchk(8'h81, 32'(`VCS_RATIO_RST));
    rchk(8'hC0, 32'h0);
    wreg(8'h01, 16'h1234);
    rchk(8'h01, 32'h0);
    for (int k = 0; k < 2; k++)
    begin
      // offset plus count stays inside the 12-pixel, 7-line field
      wreg(8'h02 + 8'(k * 8'h89), 16'd3);
      wreg(8'h03 + 8'(k * 8'h89), 16'd6);
      wreg(8'h04 + 8'(k * 8'h89), 16'd2);
      wreg(8'h05 + 8'(k * 8'h89), 16'd4);
    end
    rchk(8'h8C, 32'd6);
    run(24, 1'b1);
    run(24, 1'b1);
    wreg(8'h81, 16'h7FFF);
    run(12, 1'b0);
    wreg(8'h81, 16'hFFFF);
    wreg(8'h82, 16'h7FFF);
    run(12, 1'b0);
    wreg(8'h80, 16'h000F);
    rchk(8'h80, 32'h0000000F);
    wreg(8'hC0, 16'h0003);
    wreg(8'hC1, 16'h000B);
    pb_auto = 1'b1;
    pb_dvr = 1'b1;
    run(12, 1'b0);
    rchk(8'hC2, 32'({lid, 8'h00}));
    wreg(8'hC1, 16'h0005);
    pb_dvr = 1'b0;
    run(12, 1'b0);
    end_of_test();
  end
endmodule : tb_top
